// >>> include/dsi_defines.svh
// Offsets, field positions, reset values and signature constants of the display status block.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef DSI_DEFINES_SVH
`define DSI_DEFINES_SVH
`define DSI_OFS_STATUS 8'h48
`define DSI_OFS_MASK 8'h4A
`define DSI_OFS_INTERVAL 8'h4C
`define DSI_OFS_OPCODE 8'h4E
`define DSI_DUMP_ID_SIG 8'h3D
`define DSI_BIT_FRAME 7
`define DSI_BIT_UNKNOWN 6
`define DSI_BIT_RSVD 5
`define DSI_BIT_UNDERRUN 4
`define DSI_BIT_VBLANK 3
`define DSI_BIT_EVEN 2
`define DSI_BIT_ODD 1
`define DSI_BIT_DONE 0
`define DSI_OPC_BIT_SIG_EN 14
`define DSI_OPC_BIT_END_LIST 0
`define DSI_STATUS_RESET 8'h00
`define DSI_MASK_RESET 8'hFF
`define DSI_INTERVAL_RESET 8'h00
`define DSI_OPCODE_RESET 16'h0001
`define DSI_SIG_SEED 16'hFFFF
`define DSI_SIG_TAPS 16'h1021
`endif

// >>> include/dsi_pkg.sv
// Types used by the display status block's strap mode decode; the signature analyser uses none of them.
// Assumes the defines header is on the include path.
package dsi_pkg;
	typedef enum logic [2:0] {
		DSI_MODE_NORMAL,
		DSI_MODE_RESERVED,
		DSI_MODE_DISPLAY_TEST,
		DSI_MODE_DRIVE_HIGH,
		DSI_MODE_DRIVE_LOW,
		DSI_MODE_TRISTATE
	} dsi_mode_t;
endpackage

// >>> include/dsi_sig_if.sv
// Carrier between the status block and the signature analyser.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface dsi_sig_if;
	logic enable;
	logic pixel_valid;
	logic [7:0] pixel;
	logic frame_end;
	logic [15:0] signature;
	modport ctrl (output enable, output pixel_valid, output pixel, output frame_end,
		input signature);
	modport sig (input enable, input pixel_valid, input pixel, input frame_end,
		output signature);
endinterface

// >>> rtl/dsi_signature.sv
// Sixteen-bit LFSR signature analyser over the video pixel stream.
// Assumes pixel and frame strobes come from logic on the system clock.
`timescale 1ns/1ps
`include "dsi_defines.svh"
module dsi_signature (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	dsi_sig_if.sig sig_port
);
	logic [15:0] lfsr_reg;
	logic [15:0] lfsr_next;
	logic [15:0] latch_reg;
	logic [15:0] latch_next;
	logic [15:0] shifted;

	always_comb begin
		shifted = {lfsr_reg[14:0], 1'b0} ^ ({16{lfsr_reg[15]}} & `DSI_SIG_TAPS);
		lfsr_next = lfsr_reg;
		latch_next = latch_reg;
		if (sig_port.enable && sig_port.pixel_valid) begin
			lfsr_next = shifted ^ {8'h00, sig_port.pixel};
		end
		if (sig_port.frame_end) begin
			// The frame's signature is held while the next frame starts afresh.
			latch_next = lfsr_reg;
			lfsr_next = `DSI_SIG_SEED;
		end
		if (!sig_port.enable) begin
			lfsr_next = `DSI_SIG_SEED;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			lfsr_reg <= `DSI_SIG_SEED;
			latch_reg <= 16'h0000;
		end else begin
			lfsr_reg <= lfsr_next;
			latch_reg <= latch_next;
		end
	end

	assign sig_port.signature = latch_reg;
endmodule

// >>> rtl/dsi_status_top.sv
// Display status and interrupt block with test mode strapping and pin conditioning.
// Assumes display engine strobes share the system clock; strap pins are asynchronous.
`timescale 1ns/1ps
`include "dsi_defines.svh"
module dsi_status_top (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_memory_io_select,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_dump_req,
	input wire logic [7:0] i_dump_id,
	input wire logic i_frame_end,
	input wire logic i_cmd_issue,
	input wire logic i_cmd_known,
	input wire logic i_cmd_list_end,
	input wire logic i_loop_mode,
	input wire logic i_fifo_underrun,
	input wire logic i_line_blank_interval,
	input wire logic i_vsync_blank,
	input wire logic i_interlace,
	input wire logic i_field_even,
	input wire logic [7:0] i_pixel,
	input wire logic i_pixel_valid,
	input wire logic [7:0] i_field_fill_color,
	output logic o_irq,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_ack,
	output logic [15:0] o_dump_data,
	output logic o_dump_ack,
	output logic o_cmd_execute,
	output logic o_force_eol,
	output logic o_fetch_start,
	output logic [7:0] o_video_pixel_bus,
	output logic o_video_oe,
	output logic o_pins_value,
	output logic o_pins_force,
	output logic o_pins_tristate,
	output logic o_display_test_mode
);
	dsi_sig_if sig_bus ();

	// Strap synchronisers and mode capture.
	logic [2:0] strap_s1_reg;
	logic [2:0] strap_s2_reg;
	logic reset_d_reg;
	dsi_pkg::dsi_mode_t mode_reg;
	dsi_pkg::dsi_mode_t mode_next;

	function automatic dsi_pkg::dsi_mode_t decode_mode(input logic [2:0] code);
		case (code)
			3'h0: decode_mode = dsi_pkg::DSI_MODE_RESERVED;
			3'h1: decode_mode = dsi_pkg::DSI_MODE_RESERVED;
			3'h2: decode_mode = dsi_pkg::DSI_MODE_DISPLAY_TEST;
			3'h3: decode_mode = dsi_pkg::DSI_MODE_DRIVE_HIGH;
			3'h4: decode_mode = dsi_pkg::DSI_MODE_DRIVE_LOW;
			3'h5: decode_mode = dsi_pkg::DSI_MODE_TRISTATE;
			default: decode_mode = dsi_pkg::DSI_MODE_NORMAL;
		endcase
	endfunction

	always_comb begin
		mode_next = mode_reg;
		if (reset_d_reg && !i_reset) begin
			mode_next = decode_mode(strap_s2_reg);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		strap_s1_reg <= {i_rd_n, i_wr_n, i_memory_io_select};
		strap_s2_reg <= strap_s1_reg;
		reset_d_reg <= i_reset;
		if (i_reset) begin
			mode_reg <= dsi_pkg::DSI_MODE_NORMAL;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Registers, status flags and interrupt.
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] mask_reg;
	logic [7:0] mask_next;
	logic [7:0] interval_reg;
	logic [7:0] interval_next;
	logic [15:0] opcode_reg;
	logic [15:0] opcode_next;
	logic [7:0] frame_cnt_reg;
	logic [7:0] frame_cnt_next;
	logic loop_d_reg;
	logic irq_next;
	logic [15:0] rdata_next;
	logic [7:0] set_bits;
	logic [7:0] clear_bits;
	logic status_read;
	logic list_done;

	always_comb begin
		status_read = i_reg_rd && (i_reg_addr == `DSI_OFS_STATUS);
		// A command list that ends inside loop mode reports only on loop exit.
		list_done = (i_cmd_list_end && !i_loop_mode) || (loop_d_reg && !i_loop_mode);
		set_bits = 8'h00;
		frame_cnt_next = frame_cnt_reg;
		if (i_frame_end) begin
			if (frame_cnt_reg == interval_reg) begin
				set_bits[`DSI_BIT_FRAME] = 1'b1;
				frame_cnt_next = 8'h00;
			end else begin
				frame_cnt_next = frame_cnt_reg + 8'h01;
			end
		end
		set_bits[`DSI_BIT_UNKNOWN] = i_cmd_issue && !i_cmd_known;
		set_bits[`DSI_BIT_UNDERRUN] = i_fifo_underrun;
		set_bits[`DSI_BIT_VBLANK] = i_vsync_blank;
		set_bits[`DSI_BIT_EVEN] = i_interlace && i_field_even;
		set_bits[`DSI_BIT_ODD] = i_interlace && !i_field_even;
		set_bits[`DSI_BIT_DONE] = list_done;
		clear_bits = status_read ? ~mask_reg : 8'h00;
		// A flag raised in the reading cycle survives the clear.
		status_next = ((status_reg & ~clear_bits) | set_bits) & ~(8'h01 << `DSI_BIT_RSVD);
		irq_next = |(status_next & ~mask_reg);
		mask_next = mask_reg;
		interval_next = interval_reg;
		opcode_next = opcode_reg;
		if (i_reg_wr) begin
			case (i_reg_addr)
				`DSI_OFS_MASK: mask_next = i_reg_wdata[7:0];
				`DSI_OFS_INTERVAL: interval_next = i_reg_wdata[7:0];
				`DSI_OFS_OPCODE: opcode_next = i_reg_wdata;
				default: mask_next = mask_reg;
			endcase
		end
		if (list_done) begin
			opcode_next[`DSI_OPC_BIT_END_LIST] = 1'b1;
		end
		case (i_reg_addr)
			`DSI_OFS_STATUS: rdata_next = {8'h00, status_reg};
			`DSI_OFS_MASK: rdata_next = {8'h00, mask_reg};
			`DSI_OFS_INTERVAL: rdata_next = {8'h00, interval_reg};
			`DSI_OFS_OPCODE: rdata_next = opcode_reg;
			default: rdata_next = 16'h0000;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			status_reg <= `DSI_STATUS_RESET;
			mask_reg <= `DSI_MASK_RESET;
			interval_reg <= `DSI_INTERVAL_RESET;
			opcode_reg <= `DSI_OPCODE_RESET;
			frame_cnt_reg <= 8'h00;
			loop_d_reg <= 1'b0;
			o_irq <= 1'b0;
			o_reg_rdata <= 16'h0000;
			o_reg_ack <= 1'b0;
		end else begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			interval_reg <= interval_next;
			opcode_reg <= opcode_next;
			frame_cnt_reg <= frame_cnt_next;
			loop_d_reg <= i_loop_mode;
			o_irq <= irq_next;
			o_reg_rdata <= i_reg_rd ? rdata_next : o_reg_rdata;
			o_reg_ack <= i_reg_rd;
		end
	end

	// Line handling, video output, signature and pin conditioning.
	logic fill_reg;
	logic fill_next;
	logic blank_d_reg;
	logic fetch_next;
	logic [7:0] video_next;
	logic video_oe_next;
	logic test_mode;

	assign sig_bus.enable = test_mode && opcode_reg[`DSI_OPC_BIT_SIG_EN];
	assign sig_bus.pixel_valid = i_pixel_valid && !fill_reg;
	assign sig_bus.pixel = i_pixel;
	assign sig_bus.frame_end = i_frame_end;

	dsi_signature u_signature (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.sig_port(sig_bus.sig)
	);

	always_comb begin
		test_mode = (mode_reg == dsi_pkg::DSI_MODE_DISPLAY_TEST);
		fetch_next = i_line_blank_interval && !blank_d_reg;
		fill_next = fill_reg;
		if (i_fifo_underrun) begin
			fill_next = 1'b1;
		end else if (fetch_next) begin
			fill_next = 1'b0;
		end
		video_oe_next = 1'b1;
		video_next = fill_next ? i_field_fill_color : i_pixel;
		if (test_mode && sig_bus.enable && i_line_blank_interval) begin
			// The analyser's eight low bits fit the pixel bus; the high byte only dumps.
			video_next = sig_bus.signature[7:0];
		end
		case (mode_reg)
			dsi_pkg::DSI_MODE_DRIVE_HIGH: video_next = 8'hFF;
			dsi_pkg::DSI_MODE_DRIVE_LOW: video_next = 8'h00;
			dsi_pkg::DSI_MODE_TRISTATE: video_oe_next = 1'b0;
			default: video_oe_next = 1'b1;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			fill_reg <= 1'b0;
			blank_d_reg <= 1'b0;
			o_cmd_execute <= 1'b0;
			o_force_eol <= 1'b0;
			o_fetch_start <= 1'b0;
			o_video_pixel_bus <= 8'h00;
			o_video_oe <= 1'b1;
			o_dump_data <= 16'h0000;
			o_dump_ack <= 1'b0;
			o_pins_value <= 1'b0;
			o_pins_force <= 1'b0;
			o_pins_tristate <= 1'b0;
			o_display_test_mode <= 1'b0;
		end else begin
			fill_reg <= fill_next;
			blank_d_reg <= i_line_blank_interval;
			o_cmd_execute <= i_cmd_issue && i_cmd_known;
			o_force_eol <= i_fifo_underrun;
			o_fetch_start <= fetch_next;
			o_video_pixel_bus <= video_next;
			o_video_oe <= video_oe_next;
			if (i_dump_req) begin
				o_dump_data <= (i_dump_id == `DSI_DUMP_ID_SIG) ? sig_bus.signature : 16'h0000;
			end
			o_dump_ack <= i_dump_req;
			o_pins_value <= (mode_reg == dsi_pkg::DSI_MODE_DRIVE_HIGH);
			o_pins_force <= (mode_reg == dsi_pkg::DSI_MODE_DRIVE_HIGH) ||
				(mode_reg == dsi_pkg::DSI_MODE_DRIVE_LOW);
			o_pins_tristate <= (mode_reg == dsi_pkg::DSI_MODE_TRISTATE);
			o_display_test_mode <= test_mode;
		end
	end
endmodule

// >>> tb/dsi_host_model.sv
// Host processor model driving register reads and writes.
// Assumes one-cycle strobes sampled at the rising clock edge.
`timescale 1ns/1ps
module dsi_host_model (
	input wire logic i_sys_clk,
	output logic o_rd,
	output logic o_wr,
	output logic [7:0] o_addr,
	output logic [15:0] o_wdata
);
	initial begin
		{o_rd, o_wr, o_addr, o_wdata} = '0;
	end
	// The host releases the interrupt by reading status or by writing the mask.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		o_rd <= !w;
		o_wr <= w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_sys_clk);
		{o_rd, o_wr} <= 2'b00;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
endmodule

// >>> tb/dsi_status_assertions.sv
// Checker for the display status block, bound to its top module.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/1ps
module dsi_status_assertions (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_cmd_issue,
	input wire logic i_cmd_known,
	input wire logic i_fifo_underrun,
	input wire logic i_line_blank_interval,
	input wire logic i_dump_req,
	input wire logic o_irq,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_reg_ack,
	input wire logic o_dump_ack,
	input wire logic o_cmd_execute,
	input wire logic o_force_eol,
	input wire logic o_fetch_start,
	input wire logic o_display_test_mode,
	input wire logic o_pins_force,
	input wire logic o_pins_tristate
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	sequence status_rd;
		i_reg_rd && i_reg_addr == 8'h48;
	endsequence
	read_ack_a: assert property (i_reg_rd |=> o_reg_ack)
		else $error("read not answered");
	rsvd_zero_a: assert property (status_rd |=> o_reg_rdata[15:5] == 11'h000 ||
		o_reg_rdata[15:8] == 8'h00 && !o_reg_rdata[5]) else $error("reserved bit set");
	irq_hold_a: assert property (o_irq && !i_reg_rd && !i_reg_wr |=> o_irq)
		else $error("interrupt dropped early");
	cmd_skip_a: assert property (i_cmd_issue |=> o_cmd_execute == $past(i_cmd_known))
		else $error("command execute wrong");
	eol_force_a: assert property (i_fifo_underrun |=> o_force_eol)
		else $error("no end of line");
	fetch_new_a: assert property ($rose(i_line_blank_interval) |=> o_fetch_start)
		else $error("no fetch start");
	dump_ack_a: assert property (i_dump_req |=> o_dump_ack)
		else $error("dump not answered");
	pin_mode_a: assert property (o_display_test_mode |-> !o_pins_force && !o_pins_tristate)
		else $error("two modes at once");
endmodule
bind dsi_status_top dsi_status_assertions chk_u (.*);

// >>> tb/tb.sv
// Self-checking bench for the display status block.
// Assumes the design, checker and host model are compiled first.
`timescale 1ns/1ps
`include "dsi_defines.svh"
module tb;
	logic clk, rst, iss, known, lend, loop, und, lblank, vs, ilace, even, fend, dreq;
	logic rd, wr, irq, ack, tm, pf, pv, pt;
	logic [2:0] strap, e3;
	logic [7:0] pix, addr, m;
	logic [15:0] wd, rdata;
	logic [15:0] ddata, sig_m;
	logic [7:0] did, vpix;
	logic voe, sig_on;
	logic [15:0] exp_q[$];
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	dsi_host_model host_u (.i_sys_clk(clk), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wd));
	dsi_status_top dut_u (.i_sys_clk(clk), .i_reset(rst), .i_rd_n(strap[2]), .i_wr_n(strap[1]),
		.i_memory_io_select(strap[0]), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(addr),
		.i_reg_wdata(wd), .i_dump_req(dreq), .i_dump_id(did), .i_frame_end(fend),
		.i_cmd_issue(iss), .i_cmd_known(known), .i_cmd_list_end(lend), .i_loop_mode(loop),
		.i_fifo_underrun(und), .i_line_blank_interval(lblank), .i_vsync_blank(vs),
		.i_interlace(ilace), .i_field_even(even), .i_pixel(pix), .i_pixel_valid(1'b1),
		.i_field_fill_color(~pix), .o_irq(irq), .o_reg_rdata(rdata), .o_reg_ack(ack),
		.o_dump_data(ddata), .o_dump_ack(), .o_cmd_execute(), .o_force_eol(), .o_fetch_start(),
		.o_video_pixel_bus(vpix), .o_video_oe(voe), .o_pins_value(pv), .o_pins_force(pf),
		.o_pins_tristate(pt), .o_display_test_mode(tm));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Reference signature step: shift left, fold the top bit through the taps, add the pixel.
	function automatic logic [15:0] lfsr_step(input logic [15:0] s, input logic [7:0] p);
		lfsr_step = {s[14:0], 1'b0} ^ ({16{s[15]}} & `DSI_SIG_TAPS) ^ {8'h00, p};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host_u.xfer(1'b0, a, 16'h0000);
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		tick(12);
		rst <= 1'b0;
		tick(3);
	endtask
	// Results are compared where they appear; the queue keeps issue order.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pix <= 8'($urandom);
		// The model steps on the same pixel the design samples at this edge.
		if (rst) begin
			sig_m <= `DSI_SIG_SEED;
		end else if (sig_on) begin
			sig_m <= lfsr_step(sig_m, pix);
		end
		if (ack === 1'b1 && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
		if (cyc == 3000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		rst = 1'b1;
		strap = 3'h6;
		sig_on = 1'b0;
		did = 8'h3D;
		{iss, known, lend, loop, und, lblank, vs, ilace, even, fend, dreq} = '0;
		void'($urandom(26));
		do_reset();
		rd_exp(8'h48, 16'h0000);
		rd_exp(8'h4A, 16'h00FF);
		rd_exp(8'h10, 16'h0000);
		$display("test reset done");
		{iss, und, lend, fend, dreq, lblank} <= '1;
		tick(1);
		{iss, und, lend, fend, dreq} <= '0;
		tick(2);
		chk(16'(irq), 16'h0000);
		rd_exp(8'h48, 16'h00D1);
		rd_exp(8'h48, 16'h00D1);
		m = 8'($urandom);
		host_u.xfer(1'b1, 8'h4A, {8'h00, m});
		tick(2);
		chk(16'(irq), 16'(|(8'hD1 & ~m)));
		rd_exp(8'h48, 16'h00D1);
		rd_exp(8'h48, {8'h00, 8'hD1 & m});
		chk(16'(irq), 16'h0000);
		host_u.xfer(1'b1, 8'h4A, 16'h0000);
		rd_exp(8'h48, {8'h00, 8'hD1 & m});
		rd_exp(8'h48, 16'h0000);
		$display("test flags done");
		{loop, iss, known, lend} <= '1;
		tick(1);
		{iss, lend, lblank} <= '0;
		tick(2);
		rd_exp(8'h48, 16'h0000);
		loop <= 1'b0;
		tick(2);
		rd_exp(8'h48, 16'h0001);
		host_u.xfer(1'b1, 8'h4C, 16'h0002);
		repeat (3) begin
			rd_exp(8'h48, 16'h0000);
			fend <= 1'b1;
			tick(1);
			fend <= 1'b0;
		end
		rd_exp(8'h48, 16'h0080);
		$display("test count done");
		{vs, ilace, even} <= '1;
		tick(3);
		rd_exp(8'h48, 16'h000C);
		{vs, even} <= '0;
		tick(3);
		rd_exp(8'h48, 16'h000E);
		ilace <= 1'b0;
		tick(2);
		rd_exp(8'h48, 16'h0002);
		$display("test levels done");
		for (int c = 0; c < 7; c++) begin
			strap <= 3'(c);
			do_reset();
			e3 = {c == 2, c == 3 || c == 4, c == 5};
			chk({13'h0, tm, pf, pt}, {13'h0, e3});
			if (pf === 1'b1) chk(16'(pv), 16'(c == 3));
			if (pf === 1'b1) chk({8'h00, vpix}, (c == 3) ? 16'h00FF : 16'h0000);
			chk(16'(voe), 16'(c != 5));
			$display("test strap %0d done", c);
		end
		strap <= 3'h2;
		do_reset();
		fend <= 1'b1;
		tick(1);
		fend <= 1'b0;
		dreq <= 1'b1;
		tick(1);
		dreq <= 1'b0;
		tick(1);
		chk(ddata, `DSI_SIG_SEED);
		host_u.xfer(1'b1, 8'h4E, 16'h4000);
		sig_on <= 1'b1;
		tick(20);
		fend <= 1'b1;
		sig_on <= 1'b0;
		tick(1);
		fend <= 1'b0;
		dreq <= 1'b1;
		tick(1);
		dreq <= 1'b0;
		tick(1);
		chk(ddata, sig_m);
		did <= 8'h3C;
		dreq <= 1'b1;
		tick(1);
		dreq <= 1'b0;
		did <= 8'h3D;
		lblank <= 1'b1;
		tick(2);
		chk(ddata, 16'h0000);
		chk({8'h00, vpix}, {8'h00, sig_m[7:0]});
		lblank <= 1'b0;
		$display("test signature done");
		// A read that was never answered leaves its note behind.
		chk(16'(exp_q.size()), 16'h0000);
		tally_and_finish();
	end
endmodule
